// ===== sweep_list_pkg.sv
// Constants, register map and carrier types of the sweep and list sequencer
package sweep_list_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE    = 8'h04;
    localparam logic [7:0] ADDR_CFG     = 8'h05;
    localparam logic [7:0] ADDR_START   = 8'h06;
    localparam logic [7:0] ADDR_STOP    = 8'h07;
    localparam logic [7:0] ADDR_STEP    = 8'h08;
    localparam logic [7:0] ADDR_DWELL   = 8'h09;
    localparam logic [7:0] ADDR_REPEAT  = 8'h0a;
    localparam logic [7:0] ADDR_POINTS  = 8'h0c;
    localparam logic [7:0] ADDR_LOADER  = 8'h0d;
    localparam logic [7:0] ADDR_SOFTTRG = 8'h0f;

    // ------------------------------------------------------------------
    // Widths, codes and reset values
    // ------------------------------------------------------------------
    localparam int unsigned FREQ_W    = 40;
    localparam int unsigned CNT_W     = 32;
    localparam int unsigned PTR_W     = 11;
    localparam int unsigned DEPTH     = 2048;
    localparam logic [PTR_W-1:0]  PTR_MAX    = 11'h7ff;
    localparam logic [FREQ_W-1:0] LOAD_ARM   = 40'h0000000000;
    localparam logic [FREQ_W-1:0] LOAD_STOP  = 40'hffffffffff;
    localparam logic [FREQ_W-1:0] FREQ_RST   = 40'h0000000000;
    localparam logic [CNT_W-1:0]  CNT_RST    = 32'h00000000;
    localparam logic [7:0]        CFG_RST    = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS     = 40;
    localparam int unsigned DWELL_TICK_US     = 500;
    localparam int unsigned DWELL_TICK_CYCLES =
        (DWELL_TICK_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned TICK_W            = 16;
    localparam int unsigned TRIG_PULSE_NS     = 1000;
    localparam int unsigned TRIG_PULSE_CYCLES =
        (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PULSE_W           = 8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              wr;
        logic [7:0]        addr;
        logic [FREQ_W-1:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic trig_out_mode;
        logic trig_out_en;
        logic return_to_start;
        logic step_on_trigger;
        logic hw_trigger;
        logic triangular;
        logic reverse;
        logic point_source_select;
    } cfg_t;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_DWELL = 2'b01,
        SEQ_STEP  = 2'b10
    } seq_state_t;

endpackage

// ===== dwell_tick_gen.sv
// Free-running dwell timebase tick generator
`timescale 1ns/1ps
`default_nettype none
module dwell_tick_gen
    import sweep_list_pkg::*;
#(
    parameter int unsigned PERIOD = DWELL_TICK_CYCLES
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    output logic      tick_o
);

    // ------------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------------
    logic [TICK_W-1:0] cnt_r;
    wire               wrap = (cnt_r == TICK_W'(PERIOD - 1));

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r  <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_r  <= wrap ? '0 : cnt_r + 1'b1;
            tick_o <= wrap;
        end
    end

endmodule
`default_nettype wire

// ===== sweep_list_sequencer.sv
// Sweep and list sequencer: registers, list loader, stepping and trigger out
`timescale 1ns/1ps
`default_nettype none
module sweep_list_sequencer
    import sweep_list_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = DWELL_TICK_CYCLES
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire reg_wr_t           reg_wr_i,
    input  wire logic              external_event_input_pin_i,
    output logic [FREQ_W-1:0]      frequency_o,
    output logic                   running_o,
    output logic                   pulse_output_pin_o,
    output logic [PTR_W-1:0]       load_pointer_o,
    output logic                   loader_armed_o
);

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    wire wr_mode    = reg_wr_i.wr && (reg_wr_i.addr == ADDR_MODE);
    wire wr_cfg     = reg_wr_i.wr && (reg_wr_i.addr == ADDR_CFG);
    wire wr_start   = reg_wr_i.wr && (reg_wr_i.addr == ADDR_START);
    wire wr_stop    = reg_wr_i.wr && (reg_wr_i.addr == ADDR_STOP);
    wire wr_step    = reg_wr_i.wr && (reg_wr_i.addr == ADDR_STEP);
    wire wr_dwell   = reg_wr_i.wr && (reg_wr_i.addr == ADDR_DWELL);
    wire wr_repeat  = reg_wr_i.wr && (reg_wr_i.addr == ADDR_REPEAT);
    wire wr_points  = reg_wr_i.wr && (reg_wr_i.addr == ADDR_POINTS);
    wire wr_loader  = reg_wr_i.wr && (reg_wr_i.addr == ADDR_LOADER);
    wire wr_softtrg = reg_wr_i.wr && (reg_wr_i.addr == ADDR_SOFTTRG);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic              sweep_mode_r;
    cfg_t              cfg_r;
    logic [FREQ_W-1:0] start_r;
    logic [FREQ_W-1:0] stop_r;
    logic [FREQ_W-1:0] step_r;
    logic [CNT_W-1:0]  dwell_r;
    logic [CNT_W-1:0]  repeat_r;
    logic [CNT_W-1:0]  points_r;

    // ------------------------------------------------------------------
    // List loader decode
    // ------------------------------------------------------------------
    logic              armed_r;
    logic              full_r;
    logic [PTR_W-1:0]  ptr_r;

    wire load_arm   = wr_loader && (reg_wr_i.data == LOAD_ARM);
    wire load_end   = wr_loader && (reg_wr_i.data == LOAD_STOP);
    wire load_store = wr_loader && armed_r && !full_r && !load_arm
                      && !load_end;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sweep_mode_r <= 1'b0;
            cfg_r        <= cfg_t'(CFG_RST);
            start_r      <= FREQ_RST;
            stop_r       <= FREQ_RST;
            step_r       <= FREQ_RST;
            dwell_r      <= CNT_RST;
            repeat_r     <= CNT_RST;
        end else begin
            if (wr_mode) begin
                sweep_mode_r <= reg_wr_i.data[0];
            end
            if (wr_cfg) begin
                cfg_r <= cfg_t'(reg_wr_i.data[7:0]);
            end
            if (wr_start) begin
                start_r <= reg_wr_i.data;
            end
            if (wr_stop) begin
                stop_r <= reg_wr_i.data;
            end
            if (wr_step) begin
                step_r <= reg_wr_i.data;
            end
            if (wr_dwell) begin
                dwell_r <= reg_wr_i.data[CNT_W-1:0];
            end
            if (wr_repeat) begin
                repeat_r <= reg_wr_i.data[CNT_W-1:0];
            end
        end
    end

    // Point count: a later direct write always overrides the loader result
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            points_r <= CNT_RST;
        end else if (wr_points) begin
            points_r <= reg_wr_i.data[CNT_W-1:0];
        end else if (load_end) begin
            points_r <= CNT_W'(ptr_r);
        end
    end

    // ------------------------------------------------------------------
    // Loader pointer
    // ------------------------------------------------------------------
    wire ptr_at_max = (ptr_r == PTR_MAX);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed_r <= 1'b0;
            full_r  <= 1'b0;
            ptr_r   <= '0;
        end else if (load_end) begin
            armed_r <= 1'b0;
        end else if (load_arm) begin
            armed_r <= 1'b1;
            full_r  <= 1'b0;
            ptr_r   <= '0;
        end else if (load_store) begin
            if (ptr_at_max) begin
                full_r <= 1'b1;
            end else begin
                ptr_r <= ptr_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // List storage
    // ------------------------------------------------------------------
    // Plain flops with no reset: contents are data, not control state
    logic [FREQ_W-1:0] table_r [DEPTH];

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        wire hit = load_store && (ptr_r == PTR_W'(i));
        always_ff @(posedge sys_clk_i) begin
            if (hit) begin
                table_r[i] <= reg_wr_i.data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Trigger input synchroniser and edge detect
    // ------------------------------------------------------------------
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            sync3_r <= 1'b1;
        end else begin
            sync1_r <= external_event_input_pin_i;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    wire pin_fall  = sync3_r && !sync2_r;
    // Nothing acts on triggers until sweep/list mode is selected
    wire hw_trig   = sweep_mode_r && cfg_r.hw_trigger && pin_fall;
    wire sw_trig   = sweep_mode_r && wr_softtrg;
    wire start_trg = cfg_r.hw_trigger ? hw_trig : sw_trig;
    // Step-on-trigger is only meaningful with the hardware trigger
    wire step_mode = cfg_r.step_on_trigger && cfg_r.hw_trigger;

    // ------------------------------------------------------------------
    // Dwell timing
    // ------------------------------------------------------------------
    logic              tick;
    logic [CNT_W-1:0]  dwell_cnt_r;

    dwell_tick_gen #(
        .PERIOD (TICK_CYCLES)
    ) u_tick (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .tick_o    (tick)
    );

    // Ticks are free running, so the dwell of a run's first point may be up to
    // one tick short; a dwell value of zero behaves as one tick
    wire [CNT_W-1:0] dwell_inc  = dwell_cnt_r + 1'b1;
    wire             dwell_done = tick && (dwell_inc >= dwell_r);

    // ------------------------------------------------------------------
    // Point sequencing
    // ------------------------------------------------------------------
    seq_state_t        state_r;
    seq_state_t        state_nxt;
    logic [PTR_W-1:0]  idx_r;
    logic [PTR_W-1:0]  idx_nxt;
    logic [FREQ_W-1:0] freq_nxt;
    logic [CNT_W-1:0]  cyc_r;
    logic [CNT_W-1:0]  cyc_nxt;
    logic              chg_nxt;
    logic              done_nxt;

    wire [PTR_W-1:0]   idx_inc    = idx_r + 1'b1;
    wire [FREQ_W:0]    sweep_sum  = {1'b0, frequency_o} + {1'b0, step_r};
    wire [FREQ_W-1:0]  first_freq = cfg_r.point_source_select
                                    ? start_r : table_r[0];
    wire [FREQ_W-1:0]  next_freq  = cfg_r.point_source_select
                                    ? sweep_sum[FREQ_W-1:0]
                                    : table_r[idx_inc];
    wire               last_point = cfg_r.point_source_select
                                    ? (sweep_sum > {1'b0, stop_r})
                                    : ((CNT_W'(idx_r) + 1'b1) >= points_r
                                       || idx_r == PTR_MAX);
    wire [CNT_W-1:0]   cyc_inc    = cyc_r + 1'b1;
    wire               final_cyc  = (repeat_r != CNT_RST)
                                    && (cyc_inc == repeat_r);
    wire               advance    = (state_r == SEQ_DWELL && dwell_done)
                                    || (state_r == SEQ_STEP && hw_trig);

    always_comb begin
        state_nxt = state_r;
        idx_nxt   = idx_r;
        freq_nxt  = frequency_o;
        cyc_nxt   = cyc_r;
        chg_nxt   = 1'b0;
        done_nxt  = 1'b0;
        unique case (state_r)
            SEQ_IDLE: begin
                if (start_trg) begin
                    state_nxt = step_mode ? SEQ_STEP : SEQ_DWELL;
                    idx_nxt   = '0;
                    freq_nxt  = first_freq;
                    cyc_nxt   = CNT_RST;
                    chg_nxt   = 1'b1;
                end
            end
            SEQ_DWELL, SEQ_STEP: begin
                if (!sweep_mode_r) begin
                    state_nxt = SEQ_IDLE;
                end else if (state_r == SEQ_DWELL ? start_trg : sw_trig) begin
                    state_nxt = SEQ_IDLE;
                end else if (advance && !last_point) begin
                    idx_nxt  = idx_inc;
                    freq_nxt = next_freq;
                    chg_nxt  = 1'b1;
                end else if (advance) begin
                    done_nxt = 1'b1;
                    cyc_nxt  = cyc_inc;
                    if (final_cyc) begin
                        state_nxt = SEQ_IDLE;
                        if (cfg_r.return_to_start) begin
                            idx_nxt  = '0;
                            freq_nxt = first_freq;
                            chg_nxt  = 1'b1;
                        end
                    end else begin
                        idx_nxt  = '0;
                        freq_nxt = first_freq;
                        chg_nxt  = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r     <= SEQ_IDLE;
            idx_r       <= '0;
            cyc_r       <= CNT_RST;
            frequency_o <= FREQ_RST;
            running_o   <= 1'b0;
            dwell_cnt_r <= CNT_RST;
        end else begin
            state_r     <= state_nxt;
            idx_r       <= idx_nxt;
            cyc_r       <= cyc_nxt;
            frequency_o <= freq_nxt;
            running_o   <= (state_nxt != SEQ_IDLE);
            if (chg_nxt || state_r == SEQ_IDLE) begin
                dwell_cnt_r <= CNT_RST;
            end else if (tick) begin
                dwell_cnt_r <= dwell_inc;
            end
        end
    end

    // ------------------------------------------------------------------
    // Trigger output
    // ------------------------------------------------------------------
    // Events are delayed one cycle so the pulse follows the new frequency
    logic               chg_r;
    logic               done_r;
    logic [PULSE_W-1:0] pulse_cnt_r;

    wire fire = cfg_r.trig_out_en
                && (cfg_r.trig_out_mode ? done_r : chg_r);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            chg_r              <= 1'b0;
            done_r             <= 1'b0;
            pulse_cnt_r        <= '0;
            pulse_output_pin_o <= 1'b0;
        end else begin
            chg_r  <= chg_nxt;
            done_r <= done_nxt;
            if (fire) begin
                pulse_cnt_r        <= PULSE_W'(TRIG_PULSE_CYCLES - 1);
                pulse_output_pin_o <= 1'b1;
            end else if (pulse_cnt_r != '0) begin
                pulse_cnt_r <= pulse_cnt_r - 1'b1;
            end else begin
                pulse_output_pin_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Loader status outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            load_pointer_o <= '0;
            loader_armed_o <= 1'b0;
        end else begin
            load_pointer_o <= ptr_r;
            loader_armed_o <= armed_r;
        end
    end

endmodule
`default_nettype wire

// ===== sweep_list_sequencer_asserts.sv
// Port checker of the sweep and list sequencer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module sweep_list_checker
    import sweep_list_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = DWELL_TICK_CYCLES
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire reg_wr_t           reg_wr_i,
    input  wire logic              external_event_input_pin_i,
    input  wire logic [FREQ_W-1:0] frequency_o,
    input  wire logic              running_o,
    input  wire logic              pulse_output_pin_o,
    input  wire logic [PTR_W-1:0]  load_pointer_o,
    input  wire logic              loader_armed_o
);
    // ----------------
    // Shadow state
    // ----------------
    logic              mode_r;
    cfg_t              cfg_r;
    logic [31:0]       dwell_r;
    logic [FREQ_W-1:0] prev_f_r;
    logic [31:0]       hold_r;
    logic [31:0]       high_r;
    wire logic         wr_ok   = reg_wr_i.wr;
    wire logic         ld_wr   = wr_ok && reg_wr_i.addr == ADDR_LOADER;
    wire logic         ld_arm  = ld_wr && reg_wr_i.data == LOAD_ARM;
    wire logic         ld_stop = ld_wr && reg_wr_i.data == LOAD_STOP;
    wire logic         ld_data = ld_wr && !ld_arm && !ld_stop;
    wire logic         soft_wr = wr_ok && reg_wr_i.addr == ADDR_SOFTTRG;
    wire logic         mode_wr = wr_ok && reg_wr_i.addr == ADDR_MODE;
    wire logic         cfg_wr  = wr_ok && reg_wr_i.addr == ADDR_CFG;
    wire logic         dw_wr   = wr_ok && reg_wr_i.addr == ADDR_DWELL;
    wire logic         moved   = frequency_o != prev_f_r;
    // A dwell of zero behaves as one tick
    wire logic [31:0]  eff_dw  = (dwell_r == 32'h0) ? 32'h1 : dwell_r;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_r   <= 1'b0;
            cfg_r    <= cfg_t'(CFG_RST);
            dwell_r  <= CNT_RST;
            prev_f_r <= FREQ_RST;
            hold_r   <= 32'h0;
            high_r   <= 32'h0;
        end else begin
            mode_r   <= mode_wr ? reg_wr_i.data[0] : mode_r;
            cfg_r    <= cfg_wr ? cfg_t'(reg_wr_i.data[7:0]) : cfg_r;
            dwell_r  <= dw_wr ? reg_wr_i.data[31:0] : dwell_r;
            prev_f_r <= frequency_o;
            hold_r   <= moved ? 32'h1 : hold_r + 32'h1;
            high_r   <= pulse_output_pin_o ? high_r + 32'h1 : 32'h0;
        end
    end

    arm_resets_ptr_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) ld_arm |-> ##2 (loader_armed_o
        && load_pointer_o == 11'h000)) else $error("arm did not reset");
    stop_disarms_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) ld_stop |-> ##2 !loader_armed_o)
        else $error("stop code left loader armed");
    ptr_advances_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) (ld_data && loader_armed_o && !$past(ld_wr)
        && load_pointer_o != PTR_MAX) |-> ##2 load_pointer_o ==
        $past(load_pointer_o, 2) + 11'h001) else $error("no advance");
    ptr_frozen_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) (ld_data && !$past(ld_wr) && (!loader_armed_o
        || load_pointer_o == PTR_MAX)) |-> ##2 load_pointer_o ==
        $past(load_pointer_o, 2)) else $error("refused write moved");
    pulse_width_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) $fell(pulse_output_pin_o) |->
        high_r == TRIG_PULSE_CYCLES) else $error("pulse width wrong");
    pulse_gated_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) $rose(pulse_output_pin_o) |->
        cfg_r.trig_out_en) else $error("pulse while disabled");
    pulse_on_step_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) (moved && running_o && cfg_r.trig_out_en
        && !cfg_r.trig_out_mode) |=> $rose(pulse_output_pin_o))
        else $error("no pulse after frequency change");
    dwell_hold_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) (moved && running_o && $past(running_o)
        && !cfg_r.step_on_trigger) |-> (hold_r <= eff_dw * TICK_CYCLES
        && hold_r > (eff_dw - 32'h1) * TICK_CYCLES))
        else $error("point held for wrong time");
    mode_gate_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) !mode_r |-> ##2 !running_o)
        else $error("running without sweep mode");
    soft_start_a: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) (soft_wr && mode_r && !cfg_r.hw_trigger
        && !running_o) |=> running_o) else $error("soft start missed");
endmodule

bind sweep_list_sequencer sweep_list_checker #(
    .TICK_CYCLES(TICK_CYCLES)
) chk (
    .sys_clk_i                  (sys_clk_i),
    .rst_i                      (rst_i),
    .reg_wr_i                   (reg_wr_i),
    .external_event_input_pin_i (external_event_input_pin_i),
    .frequency_o                (frequency_o),
    .running_o                  (running_o),
    .pulse_output_pin_o         (pulse_output_pin_o),
    .load_pointer_o             (load_pointer_o),
    .loader_armed_o             (loader_armed_o)
);
`default_nettype wire

// ===== sweep_host_model.sv
// Host-side register writer standing for the serial or USB link
`timescale 1ns/1ps
`default_nettype none
module sweep_host_model
    import sweep_list_pkg::*;
(
    input  wire logic    sys_clk_i,
    output var reg_wr_t  reg_wr_o
);
    initial reg_wr_o = '0;

    // Released lines show the inverse, never a friendly copy
    task automatic put(input logic [7:0] addr, input logic [FREQ_W-1:0] data);
        @(posedge sys_clk_i);
        reg_wr_o <= '{wr: 1'b1, addr: addr, data: data};
        @(posedge sys_clk_i);
        reg_wr_o <= '{wr: 1'b0, addr: ~addr, data: ~data};
    endtask

    // Stop sits half a step past the last point, above start
    task automatic program_sweep(input logic [FREQ_W-1:0] start,
                                 input int unsigned n,
                                 input logic [FREQ_W-1:0] step);
        put(ADDR_START, start);
        put(ADDR_STOP, start + step * FREQ_W'(n - 1) + (step >> 1));
        put(ADDR_STEP, step);
    endtask
endmodule
`default_nettype wire

// ===== sweep_list_sequencer_test.sv
// Self-checking bench of the sweep and list sequencer
`timescale 1ns/1ps
`default_nettype none
module sweep_list_sequencer_test
    import sweep_list_pkg::*;
;
    localparam int unsigned TICKS = 40;
    logic              sys_clk_i = 1'b0;
    logic              rst_i     = 1'b1;
    logic              pin_r     = 1'b1;
    logic              pulse_d   = 1'b0;
    reg_wr_t           reg_wr;
    logic [FREQ_W-1:0] freq;
    logic              running;
    logic              pulse;
    logic              armed;
    logic [PTR_W-1:0]  ptr;
    logic [FREQ_W-1:0] vals[$];
    logic [FREQ_W-1:0] seen_q[$];
    logic [FREQ_W-1:0] exp_q[$];
    logic [FREQ_W-1:0] start;
    logic [FREQ_W-1:0] step;
    int                err_count = 0;
    int                tests_run = 0;
    int                cycles    = 0;
    int                pulse_cnt = 0;

    sweep_host_model host (
        .sys_clk_i (sys_clk_i),
        .reg_wr_o  (reg_wr)
    );
    sweep_list_sequencer #(.TICK_CYCLES(TICKS)) dut (
        .sys_clk_i                  (sys_clk_i),
        .rst_i                      (rst_i),
        .reg_wr_i                   (reg_wr),
        .external_event_input_pin_i (pin_r),
        .frequency_o                (freq),
        .running_o                  (running),
        .pulse_output_pin_o         (pulse),
        .load_pointer_o             (ptr),
        .loader_armed_o             (armed)
    );

    always #20 sys_clk_i = ~sys_clk_i;

    // ----------------
    // Monitor and helpers
    // ----------------
    // Sample between edges so that output updates have landed
    always @(negedge sys_clk_i) begin
        pulse_d <= pulse;
        if (pulse === 1'b1 && pulse_d === 1'b0) pulse_cnt++;
        if (running === 1'b1 && (seen_q.size() == 0 || seen_q[$] !== freq))
            seen_q.push_back(freq);
    end

    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [FREQ_W-1:0] seen, want,
                         input string what);
        tests_run++;
        if (seen !== want) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic wrap_up;
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Expected order: the given points once per cycle
    function automatic void model(input logic [FREQ_W-1:0] pts[$], int reps);
        exp_q = {};
        for (int c = 0; c < reps; c++) begin
            foreach (pts[i]) exp_q.push_back(pts[i]);
        end
    endfunction

    task automatic setup(input logic [7:0] cfg, input logic [31:0] reps);
        host.put(ADDR_CFG, {32'h0, cfg});
        host.put(ADDR_DWELL, 40'h2);
        host.put(ADDR_REPEAT, {8'h0, reps});
    endtask

    task automatic run_check(input logic [FREQ_W-1:0] last, input int pulses,
                             input logic by_pin);
        int n;
        seen_q = {};
        pulse_cnt = 0;
        if (by_pin) begin
            @(posedge sys_clk_i);
            pin_r <= 1'b0;
            repeat (4) @(posedge sys_clk_i);
            pin_r <= 1'b1;
        end else begin
            host.put(ADDR_SOFTTRG, 40'h0);
        end
        for (n = 0; n < 8 && running !== 1'b1; n++) @(negedge sys_clk_i);
        check(running, 1, "run did not start");
        for (n = 0; n < 9000 && running === 1'b1; n++) @(negedge sys_clk_i);
        repeat (60) @(negedge sys_clk_i);
        check(n < 9000, 1, "run did not end");
        foreach (exp_q[i]) check(seen_q[i], exp_q[i], "point order");
        check(freq, last, "held point");
        check(pulse_cnt, pulses, "pulse count");
    endtask

    // ----------------
    // Scenarios
    // ----------------
    initial begin
        void'($urandom(32'hd3d781c4));
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        check({running, pulse, armed, ptr, freq}, 0, "reset outputs");
        host.put(ADDR_MODE, 40'h1);
        host.put(ADDR_LOADER, LOAD_ARM);
        repeat (2) @(negedge sys_clk_i);
        check({armed, ptr}, 12'h800, "arming");
        for (int k = 0; k < 5; k++) begin
            vals.push_back({8'(k + 1), $urandom()});
            host.put(ADDR_LOADER, vals[k]);
        end
        repeat (2) @(negedge sys_clk_i);
        check(ptr, 5, "pointer after five");
        host.put(ADDR_LOADER, LOAD_STOP);
        host.put(ADDR_LOADER, {8'h77, $urandom()});
        host.put(8'h0b, {8'h00, $urandom()});
        @(negedge sys_clk_i);
        check({armed, ptr}, 5, "frozen pointer");
        setup(8'h40, 2);
        model(vals, 2);
        run_check(vals[4], 10, 1'b0);
        host.put(ADDR_POINTS, 40'h3);
        setup(8'h20, 1);
        model(vals[0:2], 1);
        run_check(vals[0], 0, 1'b0);
        start = {8'h00, $urandom()};
        step = 40'(1000 + $urandom_range(999));
        host.program_sweep(start, 4, step);
        setup(8'hc1, 2);
        model('{start, start + step, start + 2 * step, start + 3 * step}, 2);
        run_check(start + 3 * step, 2, 1'b0);
        setup(8'h00, 0);
        model(vals[0:2], 4);
        seen_q = {};
        host.put(ADDR_SOFTTRG, 40'h0);
        for (int i = 0; i < 2000 && seen_q.size() < 10; i++) @(negedge sys_clk_i);
        check(running, 1, "endless run stopped");
        for (int i = 0; i < 10; i++) check(seen_q[i], exp_q[i], "order");
        host.put(ADDR_SOFTTRG, 40'h0);
        repeat (3) @(negedge sys_clk_i);
        check(running, 0, "second trigger");
        setup(8'h08, 1);
        model(vals[0:2], 1);
        run_check(vals[2], 0, 1'b1);
        setup(8'h00, 1);
        host.put(ADDR_MODE, 40'h0);
        host.put(ADDR_SOFTTRG, 40'h0);
        repeat (4) @(negedge sys_clk_i);
        check(running, 0, "trigger without mode");
        host.put(ADDR_LOADER, LOAD_ARM);
        repeat (DEPTH + 1) host.put(ADDR_LOADER, {8'h5a, $urandom()});
        @(negedge sys_clk_i);
        check({armed, ptr}, {1'b1, PTR_MAX}, "pointer limit");
        host.put(ADDR_LOADER, LOAD_STOP);
        repeat (2) @(negedge sys_clk_i);
        check({armed, ptr}, PTR_MAX, "stop at limit");
        wrap_up();
    end
endmodule
`default_nettype wire
